// [hdl/cms_pkg.sv]
// shared constants, types and example program for the control math sequencer
package cms_pkg;

  // ==========================================================================
  // datapath and memory geometry
  localparam int CMS_DW = 32;
  localparam int CMS_FRAC = 16;
  localparam int CMS_IW = 16;
  localparam int CMS_IMEM_DEPTH = 32;
  localparam int CMS_IMEM_AW = 5;
  localparam int CMS_SLOTS = 16;

  // ==========================================================================
  // instruction field positions
  localparam int CMS_OP_LSB = 0;
  localparam int CMS_DST_LSB = 4;
  localparam int CMS_BSEL_LSB = 8;
  localparam int CMS_ASEL_LSB = 12;
  localparam int CMS_FIELD_W = 4;

  // ==========================================================================
  // operation select codes
  localparam logic [3:0] CMS_OP_NONE = 4'h0;
  localparam logic [3:0] CMS_OP_ADD = 4'h1;
  localparam logic [3:0] CMS_OP_MUL = 4'h2;
  localparam logic [3:0] CMS_OP_SAT = 4'h3;
  localparam logic [3:0] CMS_OP_BYPA = 4'h4;
  localparam logic [3:0] CMS_OP_BYPB = 4'h5;

  // ==========================================================================
  // fixed operand bank slots
  localparam logic [3:0] CMS_A_GAIN_I = 4'h1;
  localparam logic [3:0] CMS_A_GAIN_D = 4'h2;
  localparam logic [3:0] CMS_A_COEF_C = 4'h3;
  localparam logic [3:0] CMS_A_GAIN_P = 4'h4;
  localparam logic [3:0] CMS_A_SETPOINT = 4'h5;
  localparam logic [3:0] CMS_A_FEEDBACK = 4'h6;
  localparam logic [3:0] CMS_A_MINUS1 = 4'hB;
  localparam logic [3:0] CMS_B_MINUS1 = 4'hC;
  localparam logic [3:0] CMS_B_CTRL_OUT = 4'h1;

  // ==========================================================================
  // reset values
  localparam logic [CMS_DW-1:0] CMS_DATA_RST = 32'h0000_0000;
  localparam logic [CMS_IMEM_AW:0] CMS_PROG_LEN_RST = 6'h16;

  // sample pair carried together from the source
  typedef struct packed {
    logic [CMS_DW-1:0] setpoint;
    logic [CMS_DW-1:0] feedback;
  } cms_sample_s;

  // decoded destination
  typedef struct packed {
    logic valid;
    logic bank_b;
    logic [3:0] slot;
  } cms_dest_s;

  // sequencer states, gray along idle -> run -> done
  typedef enum logic [1:0] {
    CMS_IDLE = 2'b00,
    CMS_RUN = 2'b01,
    CMS_DONE = 2'b11
  } cms_state_e;

  // example controller program loaded at reset
  localparam int CMS_EX_LEN = 22;
  localparam logic [CMS_IW-1:0] CMS_EX_PROG [CMS_EX_LEN] = '{
    16'h6CC2, 16'h5B31, 16'h0633, 16'h2652, 16'h1662, 16'h3442,
    16'hB272, 16'h82A1, 16'h7C42, 16'h7A11, 16'h93B1, 16'hA5A1,
    16'h0A03, 16'h4642, 16'hD8B5, 16'hA791, 16'h79A1, 16'h0A23,
    16'h8074, 16'h9084, 16'h07D5, 16'h08E5
  };

  // destination code to bank slot
  function automatic cms_dest_s cms_decode_dest(input logic [3:0] code);
    cms_dest_s d;
    d = '{valid: 1'b1, bank_b: 1'b1, slot: 4'h0};
    unique case (code)
      4'h0: d.slot = 4'h8;
      4'h1: d.slot = 4'h7;
      4'h2: d.slot = 4'h1;
      4'h3: d.slot = 4'h6;
      4'h4: d = '{valid: 1'b1, bank_b: 1'b0, slot: 4'h7};
      4'h5: d = '{valid: 1'b1, bank_b: 1'b0, slot: 4'h8};
      4'h6: d = '{valid: 1'b1, bank_b: 1'b0, slot: 4'h9};
      4'h7: d.slot = 4'h2;
      4'h8: d.slot = 4'h3;
      4'h9: d.slot = 4'h9;
      4'hA: d.slot = 4'hA;
      4'hB: d = '{valid: 1'b1, bank_b: 1'b0, slot: 4'hA};
      4'hC: d.slot = 4'hB;
      4'hD: d.slot = 4'h4;
      4'hE: d.slot = 4'h5;
      4'hF: d.valid = 1'b0;
    endcase
    return d;
  endfunction : cms_decode_dest

endpackage : cms_pkg

// [hdl/cms_sequencer.sv]
// control math sequencer: serial instruction engine over two operand banks
`timescale 1ns/1ps

// What this block does
// - program held as 16-bit words in array
// - run serially from index zero below length
// - low four bits select the operation
// - bits seven to four select destination
// - bits eleven to eight index B bank
// - top four bits index A bank
// - operation zero is invalid, no arithmetic
// - operation one adds A and B
// - operation two multiplies A and B
// - operation three clamps B between limits
// - operations four, five pass A, B
// - codes 4,5,6,11 write A slots 7-10
// - other codes write listed B slots
// - destination fifteen writes nowhere
// - control output taken from B slot one
// - new sample pair starts one run
// - example program first forms error term
// - example program ends saving previous states
module cms_sequencer #(
  parameter int FRAC_BITS = cms_pkg::CMS_FRAC,
  parameter int IMEM_DEPTH = cms_pkg::CMS_IMEM_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample_valid,
  input wire cms_pkg::cms_sample_s sample,
  output logic sample_ready,
  input wire logic [cms_pkg::CMS_DW-1:0] gain_p,
  input wire logic [cms_pkg::CMS_DW-1:0] gain_i,
  input wire logic [cms_pkg::CMS_DW-1:0] gain_d,
  input wire logic [cms_pkg::CMS_DW-1:0] coef_c,
  input wire logic [cms_pkg::CMS_DW-1:0] sat_min,
  input wire logic [cms_pkg::CMS_DW-1:0] sat_max,
  input wire logic [cms_pkg::CMS_IMEM_AW:0] prog_len,
  input wire logic prog_we,
  input wire logic [cms_pkg::CMS_IMEM_AW-1:0] prog_addr,
  input wire logic [cms_pkg::CMS_IW-1:0] prog_data,
  output logic busy,
  output logic run_done,
  output logic [cms_pkg::CMS_DW-1:0] control_out,
  output logic [cms_pkg::CMS_DW-1:0] operation_result
);

  localparam int DW = cms_pkg::CMS_DW;
  localparam int AW = cms_pkg::CMS_IMEM_AW;
  localparam logic signed [DW-1:0] FIX_MINUS1 = -(DW'(1) <<< FRAC_BITS);

  // ==========================================================================
  // state and storage
  cms_pkg::cms_state_e state_ff;
  cms_pkg::cms_state_e nxt_state;
  logic [AW:0] pc_ff;
  logic [AW:0] len_ff;
  logic [DW-1:0] lim_min_ff;
  logic [DW-1:0] lim_max_ff;
  logic [DW-1:0] setpoint_ff;
  logic [DW-1:0] feedback_ff;
  logic [DW-1:0] result_ff;
  logic [DW-1:0] nxt_result;
  logic [DW-1:0] ctrl_ff;
  logic done_ff;
  logic [cms_pkg::CMS_IW-1:0] imem_ff [IMEM_DEPTH];
  logic [DW-1:0] a_reg_ff [cms_pkg::CMS_SLOTS];
  logic [DW-1:0] b_reg_ff [cms_pkg::CMS_SLOTS];
  logic [DW-1:0] a_mux [cms_pkg::CMS_SLOTS];
  logic [DW-1:0] b_mux [cms_pkg::CMS_SLOTS];

  // ==========================================================================
  // decode of the current instruction
  logic [cms_pkg::CMS_IW-1:0] instr;
  logic [3:0] op_sel;
  logic [3:0] dst_sel;
  logic [3:0] bsel;
  logic [3:0] asel;
  logic [DW-1:0] a_data;
  logic [DW-1:0] b_data;
  logic signed [2*DW-1:0] product;
  cms_pkg::cms_dest_s dest;
  logic exec;
  logic last;

  // fetch straight from the array, one step per clock
  assign instr = imem_ff[pc_ff[AW-1:0]];
  assign op_sel = instr[cms_pkg::CMS_OP_LSB +: cms_pkg::CMS_FIELD_W];
  assign dst_sel = instr[cms_pkg::CMS_DST_LSB +: cms_pkg::CMS_FIELD_W];
  assign bsel = instr[cms_pkg::CMS_BSEL_LSB +: cms_pkg::CMS_FIELD_W];
  assign asel = instr[cms_pkg::CMS_ASEL_LSB +: cms_pkg::CMS_FIELD_W];
  assign a_data = a_mux[asel];
  assign b_data = b_mux[bsel];
  assign product = $signed(a_data) * $signed(b_data);
  assign dest = cms_pkg::cms_decode_dest(dst_sel);
  assign exec = (state_ff == cms_pkg::CMS_RUN);
  assign last = (pc_ff + (AW+1)'(1)) >= len_ff;

  // ==========================================================================
  // operand banks: writable and unused slots come from registers, the rest are inputs
  // and constants so the example program finds its gains and -1 in place
  always_comb begin
    for (int i = 0; i < cms_pkg::CMS_SLOTS; i++) begin
      a_mux[i] = a_reg_ff[i];
      b_mux[i] = b_reg_ff[i];
    end
    a_mux[0] = cms_pkg::CMS_DATA_RST;
    a_mux[cms_pkg::CMS_A_GAIN_I] = gain_i;
    a_mux[cms_pkg::CMS_A_GAIN_D] = gain_d;
    a_mux[cms_pkg::CMS_A_COEF_C] = coef_c;
    a_mux[cms_pkg::CMS_A_GAIN_P] = gain_p;
    a_mux[cms_pkg::CMS_A_SETPOINT] = setpoint_ff;
    a_mux[cms_pkg::CMS_A_FEEDBACK] = feedback_ff;
    a_mux[cms_pkg::CMS_A_MINUS1] = FIX_MINUS1;
    b_mux[0] = cms_pkg::CMS_DATA_RST;
    b_mux[cms_pkg::CMS_B_MINUS1] = FIX_MINUS1;
  end

  // ==========================================================================
  // arithmetic; fixed point keeps the middle of the full product
  always_comb begin
    nxt_result = result_ff;
    unique case (op_sel)
      cms_pkg::CMS_OP_NONE: nxt_result = result_ff;
      cms_pkg::CMS_OP_ADD: nxt_result = a_data + b_data;
      cms_pkg::CMS_OP_MUL: nxt_result = product[FRAC_BITS +: DW];
      cms_pkg::CMS_OP_SAT: begin
        if ($signed(b_data) < $signed(lim_min_ff)) begin
          nxt_result = lim_min_ff;
        end else if ($signed(b_data) > $signed(lim_max_ff)) begin
          nxt_result = lim_max_ff;
        end else begin
          nxt_result = b_data;
        end
      end
      cms_pkg::CMS_OP_BYPA: nxt_result = a_data;
      cms_pkg::CMS_OP_BYPB: nxt_result = b_data;
      default: nxt_result = result_ff;
    endcase
  end

  // ==========================================================================
  // sequencer: idle waits for a sample, run steps the program, done publishes
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      cms_pkg::CMS_IDLE: begin
        if (sample_valid) begin
          nxt_state = (prog_len == '0) ? cms_pkg::CMS_DONE : cms_pkg::CMS_RUN;
        end
      end
      cms_pkg::CMS_RUN: begin
        if (last) begin
          nxt_state = cms_pkg::CMS_DONE;
        end
      end
      cms_pkg::CMS_DONE: nxt_state = cms_pkg::CMS_IDLE;
      default: nxt_state = cms_pkg::CMS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= cms_pkg::CMS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // program counter restarts at zero for every run
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_ff <= '0;
    end else if (state_ff == cms_pkg::CMS_IDLE) begin
      pc_ff <= '0;
    end else if (exec) begin
      pc_ff <= pc_ff + (AW+1)'(1);
    end
  end

  // ==========================================================================
  // length, limit and sample capture at the start of a run; the copies keep
  // a mid-run change on those ports from corrupting the sequence; the gains are not copied
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      len_ff <= cms_pkg::CMS_PROG_LEN_RST;
      lim_min_ff <= cms_pkg::CMS_DATA_RST;
      lim_max_ff <= cms_pkg::CMS_DATA_RST;
      setpoint_ff <= cms_pkg::CMS_DATA_RST;
      feedback_ff <= cms_pkg::CMS_DATA_RST;
    end else if (state_ff == cms_pkg::CMS_IDLE && sample_valid) begin
      len_ff <= prog_len;
      lim_min_ff <= sat_min;
      lim_max_ff <= sat_max;
      setpoint_ff <= sample.setpoint;
      feedback_ff <= sample.feedback;
    end
  end

  // ==========================================================================
  // instruction array; writes only land while idle so a run sees one program
  generate
    for (genvar g = 0; g < IMEM_DEPTH; g++) begin : g_imem
      // clamped so the unused branch never indexes past the program table
      localparam int EXI = (g < cms_pkg::CMS_EX_LEN) ? g : 0;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          imem_ff[g] <= (g < cms_pkg::CMS_EX_LEN) ? cms_pkg::CMS_EX_PROG[EXI] : '0;
        end else if (prog_we && !busy && prog_addr == AW'(g)) begin
          imem_ff[g] <= prog_data;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // bank write-back, one generate entry per slot
  generate
    for (genvar s = 0; s < cms_pkg::CMS_SLOTS; s++) begin : g_bank
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          a_reg_ff[s] <= cms_pkg::CMS_DATA_RST;
        end else if (exec && dest.valid && !dest.bank_b && dest.slot == 4'(s)) begin
          a_reg_ff[s] <= nxt_result;
        end
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          b_reg_ff[s] <= cms_pkg::CMS_DATA_RST;
        end else if (exec && dest.valid && dest.bank_b && dest.slot == 4'(s)) begin
          b_reg_ff[s] <= nxt_result;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // last operation result, held across invalid codes and between runs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_ff <= cms_pkg::CMS_DATA_RST;
    end else if (exec) begin
      result_ff <= nxt_result;
    end
  end

  // control output only moves once the whole sequence has finished
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= cms_pkg::CMS_DATA_RST;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == cms_pkg::CMS_DONE);
      if (state_ff == cms_pkg::CMS_DONE) begin
        ctrl_ff <= b_reg_ff[cms_pkg::CMS_B_CTRL_OUT];
      end
    end
  end

  // ==========================================================================
  // outputs
  assign sample_ready = (state_ff == cms_pkg::CMS_IDLE);
  assign busy = (state_ff != cms_pkg::CMS_IDLE);
  assign run_done = done_ff;
  assign control_out = ctrl_ff;
  assign operation_result = result_ff;

endmodule : cms_sequencer

// [tb/cms_sequencer_checker.sv]
// port assertions for the control math sequencer
`timescale 1ns/1ps
module cms_sequencer_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic busy,
  input wire logic run_done,
  input wire logic [cms_pkg::CMS_DW-1:0] control_out,
  input wire logic [cms_pkg::CMS_DW-1:0] operation_result
);
  // ==========
  // run handshake
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    sample_valid && sample_ready;
  endsequence
  // an empty program is busy for one cycle only; a 63-step length needs 64
  sequence s_run;
    busy ##[1:64] run_done;
  endsequence
  a_take_runs: assert property (s_take |=> s_run)
    else $error("taken pair did not finish a run in time");
  a_ready_idle: assert property (sample_ready != busy)
    else $error("ready and busy not complementary");
  a_busy_cause: assert property ($rose(busy) |-> $past(sample_valid))
    else $error("run started without a pair");
  a_done_single: assert property (run_done |=> !run_done)
    else $error("done pulse longer than one cycle");
  a_done_idle: assert property (run_done |-> !busy && $past(busy) && sample_ready)
    else $error("done not at end of a run");
  a_out_hold: assert property (!run_done |-> $stable(control_out))
    else $error("control output moved outside run end");
  a_result_hold: assert property (!$past(busy) |-> $stable(operation_result))
    else $error("result moved while idle");
endmodule : cms_sequencer_checker

bind cms_sequencer cms_sequencer_checker i_cms_sequencer_checker (.clk(clk), .rst_b(rst_b),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .busy(busy),
  .run_done(run_done), .control_out(control_out), .operation_result(operation_result));

// [tb/cms_source.sv]
// sample source and actuator stage on the far side of the sequencer
`timescale 1ns/1ps
module cms_source (
  input wire logic clk,
  input wire logic sample_ready,
  input wire logic run_done,
  input wire logic [cms_pkg::CMS_DW-1:0] control_out,
  output cms_pkg::cms_sample_s sample,
  output logic sample_valid,
  output logic [cms_pkg::CMS_DW-1:0] actuator
);
  // idle source offers nothing
  initial begin
    sample_valid = 1'b0;
    sample = '0;
  end
  // actuator takes the output once per finished run
  always @(posedge clk) begin
    if (run_done) begin
      actuator <= control_out;
    end
  end
  // pair held whole until taken, then scrambled so stale data never matches
  task automatic offer(input logic [31:0] sp, input logic [31:0] fb);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample <= {sp, fb};
    do @(posedge clk); while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
    sample <= ~sample;
  endtask : offer
endmodule : cms_source

// [tb/test_cms_sequencer.sv]
// self-checking bench for the control math sequencer
`timescale 1ns/1ps
module test_cms_sequencer;
  // ==========
  // signals and tables
  logic clk, rst_b, sample_valid, sample_ready, prog_we, busy, run_done;
  cms_pkg::cms_sample_s sample;
  logic [31:0] gain_p, sat_min, sat_max, control_out, operation_result, actuator;
  logic [5:0] prog_len;
  logic [4:0] prog_addr;
  logic [15:0] prog_data;
  int errors, checked, cyc;
  // destination code to {b bank, slot}
  localparam logic [4:0] DMAP [15] = '{5'h18, 5'h17, 5'h11, 5'h16, 5'h07, 5'h08, 5'h09,
    5'h12, 5'h13, 5'h19, 5'h1A, 5'h0A, 5'h1B, 5'h14, 5'h15};
  // {word, result} with A4 at 3.0, B12 at -1.0, B5 left at 14.07 by the slot loop
  localparam logic [47:0] OPS [7] = '{48'h4CF1_00020000, 48'h4CF2_FFFD0000,
    48'h0CF3_FFFF8000, 48'h05F3_00008000, 48'h00F3_00000000, 48'h4CF4_00030000,
    48'h0CF5_FFFF0000};

  cms_sequencer i_cms_sequencer (.clk(clk), .rst_b(rst_b), .sample_valid(sample_valid),
    .sample(sample), .sample_ready(sample_ready), .gain_p(gain_p), .gain_i(32'h0),
    .gain_d(32'h0), .coef_c(32'h0), .sat_min(sat_min), .sat_max(sat_max),
    .prog_len(prog_len), .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
    .busy(busy), .run_done(run_done), .control_out(control_out),
    .operation_result(operation_result));
  cms_source i_cms_source (.clk(clk), .sample_ready(sample_ready), .run_done(run_done),
    .control_out(control_out), .sample(sample), .sample_valid(sample_valid),
    .actuator(actuator));

  // ==========
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // every run is at most a few dozen cycles, so this is far past any honest end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    prog_we <= 1'b1;
    prog_addr <= a;
    prog_data <= d;
    @(posedge clk);
    prog_we <= 1'b0;
  endtask : wr
  // one run: length and gain set first, then latency and result checked
  task automatic run(input logic [5:0] n, input logic [31:0] g, input logic [31:0] exp);
    int k;
    @(posedge clk);
    prog_len <= n;
    gain_p <= g;
    i_cms_source.offer(32'h00050000, 32'h00020000);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (run_done !== 1'b1 && k < 40);
    chk(32'(k), 32'(n) + 32'h1);
    chk(operation_result, exp);
  endtask : run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ==========
  // test sequence
  initial begin
    rst_b = 1'b0;
    prog_we = 1'b0;
    prog_addr = 5'h00;
    prog_data = 16'h0000;
    prog_len = 6'h00;
    gain_p = 32'h0;
    sat_min = 32'hFFFF8000;
    sat_max = 32'h00008000;
    errors = 0;
    checked = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    chk(operation_result, 32'h0);
    chk(control_out, 32'h0);
    rst_b <= 1'b1;
    run(6'h02, 32'h0, 32'h00030000);
    // whole stored program: error 3.0 clamps to 0.5, proportional gain 1.0
    run(6'h16, 32'h00010000, 32'h0);
    chk(control_out, 32'h00008000);
    $display("test stored program done");
    for (int i = 0; i < 15; i++) begin
      wr(5'h00, {8'h40, 4'(i), 4'h4});
      wr(5'h01, DMAP[i][4] ? {4'h0, DMAP[i][3:0], 8'hF5} : {DMAP[i][3:0], 12'h0F4});
      run(6'h02, {12'h000, 4'(i), 16'h1234}, {12'h000, 4'(i), 16'h1234});
      if (i == 2) begin
        chk(control_out, 32'h00021234);
        @(posedge clk);
        #1;
        chk(actuator, 32'h00021234);
      end
    end
    $display("test destinations done");
    for (int i = 0; i < 7; i++) begin
      wr(5'h00, OPS[i][47:32]);
      run(6'h01, 32'h00030000, OPS[i][31:0]);
    end
    $display("test operations done");
    wr(5'h01, 16'h0000);
    wr(5'h02, 16'h4CF6);
    wr(5'h03, 16'h4CFF);
    // word 0 still bypasses B12, so -1.0 must survive the three invalid words
    run(6'h04, 32'h00030000, 32'hFFFF0000);
    $display("test invalid codes done");
    run(6'h00, 32'h00070000, 32'hFFFF0000);
    $display("test empty program done");
    tally_and_finish();
  end
endmodule : test_cms_sequencer
